// *** design/line_imager_map.vh ***
// constants for the line imager acquisition and read-out sequencer
// assumes a 25 MHz system clock standing in for the internal oscillator
`ifndef LINE_IMAGER_MAP_VH
`define LINE_IMAGER_MAP_VH

// --------------------------------------------------------------
// phase timing, in oscillator cycles; preload count in read clocks
// --------------------------------------------------------------
`define FLUSH_CYCLES 6'd32
`define SHIFT_CYCLES 6'd26
`define SAMPLING_CYCLES 6'd37
`define START_PULSE_CYCLES 6'd3
`define PRELOAD_CLOCKS 2'd3

// --------------------------------------------------------------
// output hold period
// --------------------------------------------------------------
`define HOLD_TIME_US 50
`define CLOCK_MHZ 25
`define HOLD_CYCLES (`HOLD_TIME_US * `CLOCK_MHZ)

// --------------------------------------------------------------
// frame store layout
// --------------------------------------------------------------
`define SLOT_COUNT 3'd4
`define LONE_FRAME_SLOTS 3'd3

`endif

// *** design/pixel_fifo.v ***
// small first-in first-out buffer for pixel words on the video path
// assumes one clock; write and read handshakes are valid and ready
`timescale 1ns/1ns

module pixel_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire [AW:0] used;
  wire empty;
  wire take;
  wire put;

  // --------------------------------------------------------------
  // pointer arithmetic
  // --------------------------------------------------------------
  assign used = wr_ptr - rd_ptr;
  assign empty = (used == {(AW+1){1'b0}});
  assign in_ready = (used != DEPTH[AW:0] + {(AW+1){1'b0}}) && !(used[AW]);
  assign take = !empty && (!out_valid || out_ready);
  assign put = in_valid && in_ready;

  // write side
  always @(posedge clock) begin
    if (put) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointers and registered read port
  always @(posedge clock) begin
    if (rst || flush) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (put) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (take) begin
        out_data <= mem[rd_ptr[AW-1:0]];
        rd_ptr <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule

// *** design/frame_slots.v ***
// four-slot frame store; each slot keeps one frame's pixel words
// assumes the sequencer writes only while capturing and reads one pixel a step
`timescale 1ns/1ns

module frame_slots #(
  parameter WIDTH = 8,
  parameter PIXELS = 16,
  parameter PW = 4
) (
  input wire clock,
  input wire wr_en,
  input wire [1:0] wr_slot,
  input wire [PW-1:0] wr_pixel,
  input wire [WIDTH-1:0] wr_data,
  input wire [1:0] rd_slot,
  input wire [PW-1:0] rd_pixel,
  output reg [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:4*PIXELS-1];

  // registered read, write-first ignored on collision
  always @(posedge clock) begin
    if (wr_en) begin
      mem[{wr_slot, wr_pixel}] <= wr_data;
    end
    rd_data <= mem[{rd_slot, rd_pixel}];
  end

endmodule

// *** design/line_imager_acq_readout_seq.v ***
// acquisition and read-out sequencer of a line imager
// assumes all control pins are asynchronous; the pixel strobe is slow against the clock
`timescale 1ns/1ns
`include "line_imager_map.vh"

module line_imager_acq_readout_seq #(
  parameter WIDTH = 8,
  parameter PIXELS = 16,
  parameter PW = 4,
  parameter HOLD_CYCLES = `HOLD_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire exposure_gate,
  input wire pixel_flush_request,
  input wire stored_frames_erase,
  input wire pixel_strobe,
  input wire [WIDTH-1:0] light_level,
  output reg frame_available,
  output reg last_pixel_flag,
  output reg [WIDTH-1:0] video_p,
  output reg [WIDTH-1:0] video_n,
  output reg video_valid,
  output reg exposing
);

  // ----------------------------------------------------------------
  // acquisition states
  // ----------------------------------------------------------------
  localparam A_IDLE = 2'd0;
  localparam A_FLUSH = 2'd1;
  localparam A_EXPOSE = 2'd2;
  localparam A_SHIFT = 2'd3;
  // read-out states
  localparam R_IDLE = 2'd0;
  localparam R_SAMPLE = 2'd1;
  localparam R_CLOCK = 2'd2;
  localparam R_HOLD = 2'd3;

  // ----------------------------------------------------------------
  // synchronisers and edges
  // ----------------------------------------------------------------
  reg [1:0] gate_s;
  reg [1:0] flushreq_s;
  reg [1:0] erase_s;
  reg [1:0] strobe_s;
  reg gate_d;
  reg flushreq_d;
  reg erase_d;
  reg strobe_d;
  wire gate_rise;
  wire gate_fall;
  wire flushreq_rise;
  wire erase_rise;
  wire strobe_rise;
  wire strobe_fall;

  always @(posedge clock) begin
    if (rst) begin
      gate_s <= 2'b00;
      flushreq_s <= 2'b00;
      erase_s <= 2'b00;
      strobe_s <= 2'b00;
      gate_d <= 1'b0;
      flushreq_d <= 1'b0;
      erase_d <= 1'b0;
      strobe_d <= 1'b0;
    end else begin
      gate_s <= {gate_s[0], exposure_gate};
      flushreq_s <= {flushreq_s[0], pixel_flush_request};
      erase_s <= {erase_s[0], stored_frames_erase};
      strobe_s <= {strobe_s[0], pixel_strobe};
      gate_d <= gate_s[1];
      flushreq_d <= flushreq_s[1];
      erase_d <= erase_s[1];
      strobe_d <= strobe_s[1];
    end
  end

  assign gate_rise = gate_s[1] && !gate_d;
  assign gate_fall = !gate_s[1] && gate_d;
  assign flushreq_rise = flushreq_s[1] && !flushreq_d;
  assign erase_rise = erase_s[1] && !erase_d;
  assign strobe_rise = strobe_s[1] && !strobe_d;
  assign strobe_fall = !strobe_s[1] && strobe_d;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [1:0] acq;
  reg [5:0] acq_cnt;
  reg [5:0] req_block;
  reg [2:0] stored;
  reg [1:0] head;
  reg [2:0] slots_used;
  reg [PW-1:0] cap_pix;
  reg capture_done;
  reg [1:0] rd;
  reg [5:0] hi_cnt;
  reg [5:0] smp_cnt;
  reg [1:0] pre_cnt;
  reg [PW:0] rd_pix;
  reg [10:0] hold_cnt;
  reg [1:0] rd_slot;
  reg first_clock;
  reg frames_left;
  wire [1:0] tail;
  wire shift_busy;
  wire store_full;
  wire start_pulse;
  wire [WIDTH-1:0] slot_data;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WIDTH-1:0] fifo_out_data;
  reg fifo_in_valid;

  assign tail = head + stored[1:0];
  assign shift_busy = (acq == A_SHIFT);
  assign store_full = (stored == `SLOT_COUNT);
  // a start-width high pulse is a start pulse; while clocking it must exceed eight cycles
  assign start_pulse = strobe_fall && (hi_cnt >= `START_PULSE_CYCLES) && (rd != R_CLOCK || hi_cnt > 6'd8);

  // strobe high-time counter to tell start pulses from clocks
  always @(posedge clock) begin
    if (rst || strobe_rise) begin
      hi_cnt <= 6'd0;
    end else if (strobe_s[1] && hi_cnt != 6'd63) begin
      hi_cnt <= hi_cnt + 6'd1;
    end
  end

  // ----------------------------------------------------------------
  // acquisition sequencer
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      acq <= A_IDLE;
      acq_cnt <= 6'd0;
      req_block <= 6'd0;
      cap_pix <= {PW{1'b0}};
      capture_done <= 1'b0;
      exposing <= 1'b0;
      slots_used <= 3'd0;
    end else begin
      capture_done <= 1'b0;
      if (req_block != 6'd0) begin
        req_block <= req_block - 6'd1;
      end
      case (acq)
        A_IDLE: begin
          // flush request only honoured outside exposure and transfer
          if (flushreq_rise && !gate_s[1]) begin
            // block gates for the flush period
            req_block <= `FLUSH_CYCLES;
          end
          if (gate_rise && !store_full && req_block == 6'd0 && !flushreq_rise) begin
            acq <= A_FLUSH;
            acq_cnt <= `FLUSH_CYCLES;
          end
        end
        A_FLUSH: begin
          acq_cnt <= acq_cnt - 6'd1;
          if (acq_cnt == 6'd1) begin
            acq <= gate_s[1] ? A_EXPOSE : A_SHIFT;
            acq_cnt <= `SHIFT_CYCLES;
            exposing <= gate_s[1];
          end
        end
        A_EXPOSE: begin
          // collect while gate high, transfer on fall
          if (gate_fall) begin
            exposing <= 1'b0;
            acq <= A_SHIFT;
            acq_cnt <= `SHIFT_CYCLES;
            cap_pix <= {PW{1'b0}};
          end
        end
        A_SHIFT: begin
          cap_pix <= cap_pix + 1'b1;
          acq_cnt <= acq_cnt - 6'd1;
          if (acq_cnt == 6'd1) begin
            acq <= A_IDLE;
            capture_done <= 1'b1;
            // lone frame three slots, compacted when more follow
            slots_used <= (stored == 3'd0) ? `LONE_FRAME_SLOTS : stored + 3'd1;
          end
        end
        default: acq <= A_IDLE;
      endcase
      // erase clears pixel array unless a transfer runs
      if (erase_rise && !shift_busy) begin
        // abort to idle so a new acquisition may start at once
        if (acq != A_IDLE && !gate_rise) begin
          acq <= A_IDLE;
          exposing <= 1'b0;
        end
        slots_used <= 3'd0;
      end
    end
  end

  // ----------------------------------------------------------------
  // frame store bookkeeping
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      stored <= 3'd0;
      head <= 2'd0;
    end else if (erase_rise && !shift_busy) begin
      stored <= 3'd0;
      head <= 2'd0;
    end else begin
      // frames leave oldest first
      // every accepted start pulse pops a frame, restarts in mid-read included
      if (start_pulse && rd != R_SAMPLE && stored != 3'd0) begin
        head <= head + 2'd1;
        stored <= stored - 3'd1 + {2'b00, capture_done};
      end else if (capture_done) begin
        stored <= stored + 3'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read-out sequencer
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      rd <= R_IDLE;
      smp_cnt <= 6'd0;
      pre_cnt <= 2'd0;
      rd_pix <= {(PW+1){1'b0}};
      hold_cnt <= 11'd0;
      rd_slot <= 2'd0;
      first_clock <= 1'b0;
      frames_left <= 1'b0;
      last_pixel_flag <= 1'b0;
      fifo_in_valid <= 1'b0;
    end else begin
      fifo_in_valid <= 1'b0;
      if (start_pulse && rd != R_SAMPLE) begin
        if (stored != 3'd0) begin
          rd <= R_SAMPLE;
          smp_cnt <= `SAMPLING_CYCLES;
          rd_slot <= head;
          frames_left <= (stored > 3'd1);
          pre_cnt <= 2'd0;
          rd_pix <= {(PW+1){1'b0}};
          first_clock <= 1'b1;
        end else if (rd == R_HOLD) begin
          // a start pulse ends the hold
          rd <= R_IDLE;
        end
        last_pixel_flag <= 1'b0;
      end else begin
        case (rd)
          R_SAMPLE: begin
            smp_cnt <= smp_cnt - 6'd1;
            if (smp_cnt == 6'd1) begin
              rd <= R_CLOCK;
            end
          end
          R_CLOCK: begin
            if (strobe_rise) begin
              first_clock <= 1'b0;
              if (pre_cnt != `PRELOAD_CLOCKS) begin
                pre_cnt <= pre_cnt + 2'd1;
              end else begin
                fifo_in_valid <= fifo_in_ready;
                rd_pix <= rd_pix + 1'b1;
                if (rd_pix == PIXELS - 1) begin
                  last_pixel_flag <= 1'b1;
                  rd <= R_HOLD;
                  hold_cnt <= HOLD_CYCLES[10:0];
                end
              end
            end
          end
          R_HOLD: begin
            // drop on the next strobe edge
            if (strobe_rise) begin
              last_pixel_flag <= 1'b0;
            end
            hold_cnt <= hold_cnt - 11'd1;
            if (hold_cnt == 11'd1) begin
              rd <= R_IDLE;
            end
          end
          default: begin
            // flag still drops on a strobe edge after the hold ran out
            if (strobe_rise) begin
              last_pixel_flag <= 1'b0;
            end
            rd <= R_IDLE;
          end
        endcase
      end
    end
  end

  // frame-available output
  always @(posedge clock) begin
    if (rst) begin
      frame_available <= 1'b0;
    end else if (erase_rise && !shift_busy) begin
      frame_available <= 1'b0;
    end else if (rd == R_CLOCK && first_clock && strobe_rise && !frames_left && stored == 3'd0) begin
      // last frame leaves on the first clock
      frame_available <= 1'b0;
    end else if (capture_done) begin
      frame_available <= 1'b1;
    end else if (stored != 3'd0) begin
      frame_available <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // storage and video path
  // ----------------------------------------------------------------
  frame_slots #(.WIDTH(WIDTH), .PIXELS(PIXELS), .PW(PW)) store (
    .clock(clock),
    .wr_en(shift_busy),
    .wr_slot(tail),
    .wr_pixel(cap_pix),
    .wr_data(light_level),
    .rd_slot(rd_slot),
    .rd_pixel(rd_pix[PW-1:0]),
    .rd_data(slot_data)
  );

  pixel_fifo #(.WIDTH(WIDTH), .DEPTH(16), .AW(4)) video_fifo (
    .clock(clock),
    .rst(rst),
    .flush(start_pulse),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(slot_data),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );

  // video held between pixels, so hold period needs no extra logic
  always @(posedge clock) begin
    if (rst) begin
      video_p <= {WIDTH{1'b0}};
      video_n <= {WIDTH{1'b0}};
      video_valid <= 1'b0;
    end else begin
      video_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        video_p <= fifo_out_data;
        video_n <= ~fifo_out_data;
      end
    end
  end

endmodule

// *** tb/line_imager_seq_monitor.sv ***
// checker on the sequencer ports: video pair, hold, exposure and flag timing
// assumes it is bound into the sequencer and sees its ports only
`timescale 1ns/1ns

module line_imager_seq_monitor #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire rst,
  input wire exposure_gate,
  input wire pixel_strobe,
  input wire frame_available,
  input wire last_pixel_flag,
  input wire [WIDTH-1:0] video_p,
  input wire [WIDTH-1:0] video_n,
  input wire video_valid,
  input wire exposing
);
  // ----------------------------------------
  // relations in the single clock domain
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  pair_inverse_a:
    assert property (video_valid |-> video_n == ~video_p) else $error("video pair not inverse");
  valid_pulse_a:
    assert property (video_valid |=> !video_valid) else $error("pixel valid longer than a cycle");
  video_hold_a:
    assert property ($fell(video_valid) && last_pixel_flag |-> $stable(video_p)[*8])
    else $error("video moved after last pixel");
  expose_after_flush_a:
    assert property ($rose(exposing) |-> exposure_gate && $past(exposure_gate, 30))
    else $error("exposure began before flush ended");
  expose_in_gate_a:
    assert property (exposing |-> $past(exposure_gate, 3) || $past(exposure_gate, 4))
    else $error("exposing without gate");
  ready_after_transfer_a:
    assert property ($rose(frame_available) |-> !exposing && !$past(exposing, 20))
    else $error("frame ready before transfer done");
  last_flag_rise_a:
    assert property ($rose(last_pixel_flag) |-> ##[1:4] video_valid)
    else $error("last flag without pixel");
  last_flag_fall_a:
    assert property ($fell(last_pixel_flag) |-> $past(pixel_strobe, 3) || $past(pixel_strobe, 4))
    else $error("last flag fell without strobe");

  // main scenarios reached
  cover property ($rose(exposing));
  cover property ($rose(frame_available));
  cover property ($rose(last_pixel_flag));
endmodule

bind line_imager_acq_readout_seq line_imager_seq_monitor #(.WIDTH(WIDTH)) mon (
  .clock(clock),
  .rst(rst),
  .exposure_gate(exposure_gate),
  .pixel_strobe(pixel_strobe),
  .frame_available(frame_available),
  .last_pixel_flag(last_pixel_flag),
  .video_p(video_p),
  .video_n(video_n),
  .video_valid(video_valid),
  .exposing(exposing)
);

// *** tb/imager_host_model.sv ***
// host side: drives the pixel strobe and counts pixels on the video pair
// assumes the bench sets want and clears the counters before each read
`timescale 1ns/1ns

module imager_host_model #(
  parameter WIDTH = 8
) (
  input wire clock,
  input wire video_valid,
  input wire [WIDTH-1:0] video_p,
  input wire [WIDTH-1:0] video_n,
  output reg pixel_strobe
);
  integer count = 0;
  integer bad = 0;
  reg [WIDTH-1:0] want = 0;

  initial pixel_strobe = 1'b0;

  // start pulse
  // twelve cycles high, so it also counts as a restart mid-read
  task start_pulse;
    begin
      #13 pixel_strobe = 1'b1;
      #480 pixel_strobe = 1'b0;
      #1800;
    end
  endtask

  // read clocks
  // 320 ns period, idle low between frames; odd offset keeps it off the clock
  // short high phase so no read clock is ever taken for a start pulse
  task read_clocks(input integer n);
    begin
      repeat (n) begin
        #240 pixel_strobe = 1'b1;
        #80 pixel_strobe = 1'b0;
      end
    end
  endtask

  // tally pixels and any that miss the expected level or its inverse
  always @(posedge clock) begin
    if (video_valid) begin
      count <= count + 1;
      if (video_p !== want || video_n !== ~want) bad <= bad + 1;
    end
  end
endmodule

// *** tb/test_line_imager_acq_readout_seq.sv ***
// self-checking bench for the line imager sequencer
// assumes the host model drives the strobe; other pins move at falling edges
`timescale 1ns/1ns

module test_line_imager_acq_readout_seq;
  localparam PIXELS = 16;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg exposure_gate = 1'b0;
  reg pixel_flush_request = 1'b0;
  reg stored_frames_erase = 1'b0;
  reg [7:0] light_level = 8'h00;
  wire pixel_strobe;
  wire frame_available;
  wire last_pixel_flag;
  wire [7:0] video_p;
  wire [7:0] video_n;
  wire video_valid;
  wire exposing;
  integer fails = 0;
  integer num_checks = 0;
  integer cycles = 0;

  always #20 clock = ~clock;

  // short hold period keeps the run brief
  line_imager_acq_readout_seq #(.WIDTH(8), .PIXELS(PIXELS), .HOLD_CYCLES(20)) DUT (
    .clock(clock),
    .rst(rst),
    .exposure_gate(exposure_gate),
    .pixel_flush_request(pixel_flush_request),
    .stored_frames_erase(stored_frames_erase),
    .pixel_strobe(pixel_strobe),
    .light_level(light_level),
    .frame_available(frame_available),
    .last_pixel_flag(last_pixel_flag),
    .video_p(video_p),
    .video_n(video_n),
    .video_valid(video_valid),
    .exposing(exposing)
  );

  imager_host_model host (
    .clock(clock),
    .video_valid(video_valid),
    .video_p(video_p),
    .video_n(video_n),
    .pixel_strobe(pixel_strobe)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] want, input string what);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("wrong value at %0t: %s got %0h want %0h", $time, what, seen, want);
      end
    end
  endtask

  task wrap_up;
    begin
      if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 9000) begin
      fails = fails + 1;
      wrap_up;
    end
  end

  task idle(input integer n);
    repeat (n) @(negedge clock);
  endtask

  // gate long enough for flush plus exposure; wait out sync and transfer
  // gate pulse width
  task capture(input [7:0] level);
    begin
      light_level = level;
      exposure_gate = 1'b1;
      idle(60);
      exposure_gate = 1'b0;
      idle(40);
    end
  endtask

  task read_frame(input [7:0] level, input integer n);
    begin
      host.want = level;
      host.start_pulse;
      // a restart's own rising edge still shifts one pixel of the old read
      host.count = 0;
      host.bad = 0;
      host.read_clocks(3 + PIXELS);
      idle(6);
      check(host.count, n, "pixels read");
      check(host.bad, 0, "pixel values");
      if (n > 0) begin
        check(last_pixel_flag, 1'b1, "last flag set");
        host.read_clocks(1);
        idle(6);
        check(last_pixel_flag, 1'b0, "last flag cleared");
      end
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task single_frame;
    begin
      light_level = 8'h5A;
      exposure_gate = 1'b1;
      idle(30);
      check(exposing, 1'b0, "exposing in flush");
      idle(10);
      check(exposing, 1'b1, "exposing after flush");
      idle(20);
      exposure_gate = 1'b0;
      idle(40);
      check(exposing, 1'b0, "exposing after gate");
      check(frame_available, 1'b1, "frame ready");
      read_frame(8'h5A, PIXELS);
      check(frame_available, 1'b0, "store empty");
    end
  endtask

  // five gates: the fifth must be refused, reads come oldest first
  task multi_frame;
    integer i;
    begin
      for (i = 1; i <= 5; i = i + 1) capture(i[7:0] * 8'h11);
      for (i = 1; i <= 4; i = i + 1) begin
        check(frame_available, 1'b1, "frames left");
        read_frame(i[7:0] * 8'h11, PIXELS);
      end
      check(frame_available, 1'b0, "all read");
      read_frame(8'h00, 0);
    end
  endtask

  task flush_refusal;
    begin
      pixel_flush_request = 1'b1;
      idle(4);
      pixel_flush_request = 1'b0;
      idle(4);
      capture(8'h3C);
      check(frame_available, 1'b0, "gate in flush period");
      capture(8'h3C);
      check(frame_available, 1'b1, "gate after flush period");
      read_frame(8'h3C, PIXELS);
    end
  endtask

  task erase_store;
    begin
      capture(8'h66);
      capture(8'h77);
      stored_frames_erase = 1'b1;
      idle(4);
      stored_frames_erase = 1'b0;
      idle(8);
      check(frame_available, 1'b0, "store erased");
      read_frame(8'h00, 0);
      stored_frames_erase = 1'b1;
      capture(8'h88);
      stored_frames_erase = 1'b0;
      read_frame(8'h88, PIXELS);
    end
  endtask

  // a second start pulse in mid-read begins on the next frame
  task restart_read;
    begin
      capture(8'h21);
      capture(8'h32);
      host.want = 8'h21;
      host.count = 0;
      host.bad = 0;
      host.start_pulse;
      host.read_clocks(6);
      // let the three pixels of the first frame drain before the restart
      idle(8);
      check(host.count, 3, "pixels before restart");
      check(host.bad, 0, "first frame pixels");
      read_frame(8'h32, PIXELS);
      check(frame_available, 1'b0, "both frames gone");
    end
  endtask

  initial begin
    idle(5);
    rst = 1'b0;
    idle(3);
    check({frame_available, last_pixel_flag, video_valid, exposing, video_p, video_n}, 0, "reset outputs");
    single_frame;
    multi_frame;
    flush_refusal;
    erase_store;
    restart_read;
    wrap_up;
  end
endmodule
